// ==== shared/pcm_pkg.sv ====
// Shared constants, field layouts and carrier types of the configuration register bank
package pcm_pkg;

	// Bus geometry: a register index selects a 64-bit register, one bit picks its upper 32-bit half
	localparam int PCM_ADDR_W     = 12;
	localparam int PCM_DATA_W     = 32;
	localparam int PCM_IDX_LSB    = 2;
	localparam int PCM_IDX_W      = 6;
	localparam int PCM_HI_SEL_BIT = 8;
	localparam int PCM_TOP_LSB    = 9;

	// Register indices; byte address of the low word is four times the index
	localparam logic [5:0] PCM_IDX_LEGACY_ADDR = 6'h00;
	localparam logic [5:0] PCM_IDX_LEGACY_TYPE = 6'h01;
	localparam logic [5:0] PCM_IDX_STAMP       = 6'h10;
	localparam logic [5:0] PCM_IDX_PLATFORM    = 6'h17;
	localparam logic [5:0] PCM_IDX_IRQ_BASE    = 6'h1B;
	localparam logic [5:0] PCM_IDX_POWERON     = 6'h2A;

	// Bus response codes
	localparam logic [1:0] PCM_RESP_OKAY   = 2'h0;
	localparam logic [1:0] PCM_RESP_SLVERR = 2'h2;
	localparam logic [1:0] PCM_RESP_DECERR = 2'h3;

	// Platform identity fields
	localparam int PCM_PID_FLAG_LSB  = 50;
	localparam int PCM_PID_FLAG_W    = 3;
	localparam int PCM_PID_LAT_LSB   = 53;
	localparam int PCM_PID_LAT_W     = 4;
	localparam int PCM_PID_RATIO_BIT = 60;

	// Local interrupt controller base fields
	localparam int PCM_LIB_BSP_BIT  = 8;
	localparam int PCM_LIB_EN_BIT   = 11;
	localparam int PCM_LIB_BASE_LSB = 12;
	localparam int PCM_LIB_BASE_W   = 20;
	localparam logic       PCM_LIB_EN_RST   = 1'h1;
	localparam logic [19:0] PCM_LIB_BASE_RST = 20'h00000;

	// Hard power-on configuration: writable and strap-reported bit masks
	localparam logic [63:0] PCM_HPC_RW_MASK = 64'h0000_0000_0400_00DE;
	localparam logic [63:0] PCM_HPC_RO_MASK = 64'h0000_0000_0BFF_F700;
	localparam logic [63:0] PCM_HPC_RW_RST  = 64'h0000_0000_0000_0000;
	localparam int PCM_HPC_DATA_CHK_BIT = 1;
	localparam int PCM_HPC_RESP_CHK_BIT = 2;
	localparam int PCM_HPC_AERR_DRV_BIT = 3;
	localparam int PCM_HPC_BERR_REQ_BIT = 4;
	localparam int PCM_HPC_BERR_INT_BIT = 6;
	localparam int PCM_HPC_BINIT_BIT    = 7;
	localparam int PCM_HPC_LOWPWR_BIT   = 26;

	// Configuration levels from package pins
	typedef struct packed {
		logic [2:0]  platform_flag;
		logic [3:0]  cache_latency;
		logic        clock_ratio;
		logic        bootstrap_processor;
		logic [31:0] poweron;
	} pcm_strap_t;

	// Feature enables driven into the core
	typedef struct packed {
		logic data_err_chk;
		logic resp_err_chk;
		logic addr_err_drive;
		logic bus_err_req;
		logic bus_err_int;
		logic bus_init_drive;
		logic low_power;
	} pcm_feat_t;

endpackage

// ==== src/pcm_sync.sv ====
// Two-stage synchroniser for a vector of slow configuration levels
`timescale 1ns/1ps
module pcm_sync #(
	parameter int W = 8
) (
	input  wire logic         sys_clk,
	input  wire logic         rst,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	logic [W-1:0] meta_r;
	logic [W-1:0] meta_nxt;
	logic [W-1:0] hold_r;
	logic [W-1:0] hold_nxt;

	// First stage feeds only the second stage
	always_comb begin
		meta_nxt = din;
		hold_nxt = meta_r;
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			meta_r <= '0;
			hold_r <= '0;
		end else begin
			meta_r <= meta_nxt;
			hold_r <= hold_nxt;
		end
	end

	assign dout = hold_r;
endmodule

// ==== src/pcm_strb_merge.sv ====
// Byte-lane merge of a bus write into a stored word
`timescale 1ns/1ps
module pcm_strb_merge #(
	parameter int DW = 32
) (
	input  wire logic [DW-1:0]   old_word,
	input  wire logic [DW-1:0]   new_word,
	input  wire logic [DW/8-1:0] strb,
	output logic      [DW-1:0]   merged
);
	// Lanes without a strobe keep their stored byte
	for (genvar b = 0; b < DW/8; b++) begin : g_lane
		assign merged[b*8 +: 8] = strb[b] ? new_word[b*8 +: 8] : old_word[b*8 +: 8];
	end
endmodule

// ==== src/pcm_msr_bank.sv ====
// Processor configuration and identification register bank behind an AXI4-Lite slave
//
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/1ps
// Behaviour
// - Platform identity reports a read-only three-bit platform flag code, value n = flag n.
// - Platform identity reports a four-bit read-only second-level cache latency.
// - Platform identity reports one read-only clock frequency ratio bit.
// - Interrupt controller base bit 8 is one only on the bootstrap processor.
// - Controller global enable: one enables; once cleared stays cleared until reset.
// - Power-on configuration: writable bits enable features, read-only bits report configuration.
// - Power-on configuration bit 1 is a read-write data error checking enable.
module pcm_msr_bank
	import pcm_pkg::*;
#(
	parameter int          ADDR_W   = PCM_ADDR_W,
	parameter logic        EN_RST   = PCM_LIB_EN_RST,
	parameter logic [19:0] BASE_RST = PCM_LIB_BASE_RST
) (
	input  wire logic              sys_clk,
	input  wire logic              rst,
	// AXI4-Lite write address
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic [2:0]        s_axi_awprot,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	// AXI4-Lite write data
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	// AXI4-Lite read address
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic [2:0]        s_axi_arprot,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	// Configuration levels from pins
	input  wire pcm_strap_t        strap_pins,
	// Controls to the core
	output logic                   irq_ctrl_enable,
	output logic [19:0]            irq_ctrl_base,
	output pcm_feat_t              feature_en
);

	typedef enum logic [0:0] {
		WR_COLLECT,
		WR_RESP
	} pcm_wr_st_t;

	typedef enum logic [0:0] {
		RD_IDLE,
		RD_RESP
	} pcm_rd_st_t;

	// Result of decoding one bus address
	typedef struct packed {
		logic       hit;
		logic       ext;
		logic       hi;
		logic [5:0] idx;
	} pcm_dec_t;

	localparam int STRAP_W = $bits(pcm_strap_t);

	pcm_strap_t strap_s;
	logic [STRAP_W-1:0] strap_vec;

	// Write channel state
	pcm_wr_st_t        wr_st_r;
	pcm_wr_st_t        wr_st_nxt;
	logic              aw_have_r;
	logic              aw_have_nxt;
	logic [ADDR_W-1:0] awaddr_r;
	logic [ADDR_W-1:0] awaddr_nxt;
	logic              w_have_r;
	logic              w_have_nxt;
	logic [31:0]       wdata_r;
	logic [31:0]       wdata_nxt;
	logic [3:0]        wstrb_r;
	logic [3:0]        wstrb_nxt;
	logic [1:0]        bresp_r;
	logic [1:0]        bresp_nxt;
	logic              wr_fire;

	// Read channel state
	pcm_rd_st_t  rd_st_r;
	pcm_rd_st_t  rd_st_nxt;
	logic [31:0] rdata_r;
	logic [31:0] rdata_nxt;
	logic [1:0]  rresp_r;
	logic [1:0]  rresp_nxt;

	// Register contents
	logic        lib_en_r;
	logic        lib_en_nxt;
	logic [19:0] lib_base_r;
	logic [19:0] lib_base_nxt;
	logic [63:0] hpc_rw_r;
	logic [63:0] hpc_rw_nxt;

	// Views used by the read path and write merge
	logic [63:0] pid_view;
	logic [63:0] lib_view;
	logic [63:0] hpc_view;
	pcm_dec_t    wr_dec;
	pcm_dec_t    rd_dec;
	logic [63:0] wr_old64;
	logic [31:0] wr_old32;
	logic [31:0] wr_merged;
	logic [63:0] wr_new64;

	// Straps arrive from pins, so they cross two flops before use
	pcm_sync #(
		.W (STRAP_W)
	) u_strap_sync (
		.sys_clk (sys_clk),
		.rst     (rst),
		.din     (strap_pins),
		.dout    (strap_vec)
	);

	assign strap_s = pcm_strap_t'(strap_vec);

	// Address decode: index, half select, and a zero check on the upper bits
	function automatic pcm_dec_t decode(input logic [ADDR_W-1:0] a);
		pcm_dec_t d;
		d.idx = a[PCM_IDX_LSB +: PCM_IDX_W];
		d.hi  = a[PCM_HI_SEL_BIT];
		d.hit = 1'b0;
		d.ext = 1'b0;
		if (a[ADDR_W-1:PCM_TOP_LSB] == '0) begin
			case (d.idx)
				PCM_IDX_PLATFORM,
				PCM_IDX_IRQ_BASE,
				PCM_IDX_POWERON: d.hit = 1'b1;
				// Machine-check and counter words live in other blocks
				PCM_IDX_LEGACY_ADDR,
				PCM_IDX_LEGACY_TYPE,
				PCM_IDX_STAMP: d.ext = 1'b1;
				default: d.hit = 1'b0;
			endcase
		end
		return d;
	endfunction

	// Response code for a decoded access
	function automatic logic [1:0] resp_of(input pcm_dec_t d);
		if (d.hit) begin
			return PCM_RESP_OKAY;
		end else if (d.ext) begin
			return PCM_RESP_SLVERR;
		end
		return PCM_RESP_DECERR;
	endfunction

	// Platform identity view; everything outside the three fields reads zero
	always_comb begin
		pid_view = '0;
		pid_view[PCM_PID_FLAG_LSB +: PCM_PID_FLAG_W] = strap_s.platform_flag;
		pid_view[PCM_PID_LAT_LSB +: PCM_PID_LAT_W]   = strap_s.cache_latency;
		pid_view[PCM_PID_RATIO_BIT]                  = strap_s.clock_ratio;
	end

	// Interrupt controller base view
	always_comb begin
		lib_view = '0;
		lib_view[PCM_LIB_BSP_BIT]                      = strap_s.bootstrap_processor;
		lib_view[PCM_LIB_EN_BIT]                       = lib_en_r;
		lib_view[PCM_LIB_BASE_LSB +: PCM_LIB_BASE_W]   = lib_base_r;
	end

	// Power-on view: stored enables beside strap-reported configuration
	always_comb begin
		hpc_view = (hpc_rw_r & PCM_HPC_RW_MASK)
			| ({32'h0000_0000, strap_s.poweron} & PCM_HPC_RO_MASK);
	end

	// Write channel: address and data are taken in either order, then applied
	always_comb begin
		wr_st_nxt   = wr_st_r;
		aw_have_nxt = aw_have_r;
		awaddr_nxt  = awaddr_r;
		w_have_nxt  = w_have_r;
		wdata_nxt   = wdata_r;
		wstrb_nxt   = wstrb_r;
		bresp_nxt   = bresp_r;
		wr_fire     = 1'b0;
		case (wr_st_r)
			WR_COLLECT: begin
				if (s_axi_awvalid && s_axi_awready) begin
					aw_have_nxt = 1'b1;
					awaddr_nxt  = s_axi_awaddr;
				end
				if (s_axi_wvalid && s_axi_wready) begin
					w_have_nxt = 1'b1;
					wdata_nxt  = s_axi_wdata;
					wstrb_nxt  = s_axi_wstrb;
				end
				// Apply in the first cycle in which both halves are held
				if (aw_have_r && w_have_r) begin
					wr_fire     = 1'b1;
					bresp_nxt   = resp_of(wr_dec);
					aw_have_nxt = 1'b0;
					w_have_nxt  = 1'b0;
					wr_st_nxt   = WR_RESP;
				end
			end
			WR_RESP: begin
				if (s_axi_bready) begin
					wr_st_nxt = WR_COLLECT;
				end
			end
			default: wr_st_nxt = WR_COLLECT;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			wr_st_r   <= WR_COLLECT;
			aw_have_r <= 1'b0;
			awaddr_r  <= '0;
			w_have_r  <= 1'b0;
			wdata_r   <= 32'h0000_0000;
			wstrb_r   <= 4'h0;
			bresp_r   <= PCM_RESP_OKAY;
		end else begin
			wr_st_r   <= wr_st_nxt;
			aw_have_r <= aw_have_nxt;
			awaddr_r  <= awaddr_nxt;
			w_have_r  <= w_have_nxt;
			wdata_r   <= wdata_nxt;
			wstrb_r   <= wstrb_nxt;
			bresp_r   <= bresp_nxt;
		end
	end

	// Ready only while that half is empty and no response is pending
	assign s_axi_awready = (wr_st_r == WR_COLLECT) && !aw_have_r;
	assign s_axi_wready  = (wr_st_r == WR_COLLECT) && !w_have_r;
	assign s_axi_bvalid  = (wr_st_r == WR_RESP);
	assign s_axi_bresp   = bresp_r;

	// Select the addressed 64-bit register and the half being written
	assign wr_dec = decode(awaddr_r);

	always_comb begin
		case (wr_dec.idx)
			PCM_IDX_PLATFORM: wr_old64 = pid_view;
			PCM_IDX_IRQ_BASE: wr_old64 = lib_view;
			PCM_IDX_POWERON:  wr_old64 = hpc_view;
			default:          wr_old64 = '0;
		endcase
		wr_old32 = wr_dec.hi ? wr_old64[63:32] : wr_old64[31:0];
	end

	// Partial strobes keep the untouched bytes of the stored value
	pcm_strb_merge #(
		.DW (PCM_DATA_W)
	) u_merge (
		.old_word (wr_old32),
		.new_word (wdata_r),
		.strb     (wstrb_r),
		.merged   (wr_merged)
	);

	assign wr_new64 = wr_dec.hi ? {wr_merged, wr_old64[31:0]} : {wr_old64[63:32], wr_merged};

	// Register updates; read-only and reserved bits never take written data
	always_comb begin
		lib_en_nxt   = lib_en_r;
		lib_base_nxt = lib_base_r;
		hpc_rw_nxt   = hpc_rw_r;
		if (wr_fire && wr_dec.hit) begin
			case (wr_dec.idx)
				PCM_IDX_IRQ_BASE: begin
					// A one cannot bring the enable back; only reset does
					lib_en_nxt   = lib_en_r & wr_new64[PCM_LIB_EN_BIT];
					lib_base_nxt = wr_new64[PCM_LIB_BASE_LSB +: PCM_LIB_BASE_W];
				end
				PCM_IDX_POWERON: begin
					hpc_rw_nxt = wr_new64 & PCM_HPC_RW_MASK;
				end
				default: begin
					// Platform identity is read-only: the write is accepted and dropped
					hpc_rw_nxt = hpc_rw_r;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			lib_en_r   <= EN_RST;
			lib_base_r <= BASE_RST;
			hpc_rw_r   <= PCM_HPC_RW_RST;
		end else begin
			lib_en_r   <= lib_en_nxt;
			lib_base_r <= lib_base_nxt;
			hpc_rw_r   <= hpc_rw_nxt;
		end
	end

	// Read channel: one address accepted, data answered on the next cycle
	assign rd_dec = decode(s_axi_araddr);

	always_comb begin
		rd_st_nxt = rd_st_r;
		rdata_nxt = rdata_r;
		rresp_nxt = rresp_r;
		case (rd_st_r)
			RD_IDLE: begin
				if (s_axi_arvalid) begin
					rresp_nxt = resp_of(rd_dec);
					rdata_nxt = 32'h0000_0000;
					if (rd_dec.hit) begin
						case (rd_dec.idx)
							PCM_IDX_PLATFORM: begin
								rdata_nxt = rd_dec.hi ? pid_view[63:32] : pid_view[31:0];
							end
							PCM_IDX_IRQ_BASE: begin
								rdata_nxt = rd_dec.hi ? lib_view[63:32] : lib_view[31:0];
							end
							PCM_IDX_POWERON: begin
								rdata_nxt = rd_dec.hi ? hpc_view[63:32] : hpc_view[31:0];
							end
							default: rdata_nxt = 32'h0000_0000;
						endcase
					end
					rd_st_nxt = RD_RESP;
				end
			end
			RD_RESP: begin
				if (s_axi_rready) begin
					rd_st_nxt = RD_IDLE;
				end
			end
			default: rd_st_nxt = RD_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			rd_st_r <= RD_IDLE;
			rdata_r <= 32'h0000_0000;
			rresp_r <= PCM_RESP_OKAY;
		end else begin
			rd_st_r <= rd_st_nxt;
			rdata_r <= rdata_nxt;
			rresp_r <= rresp_nxt;
		end
	end

	assign s_axi_arready = (rd_st_r == RD_IDLE);
	assign s_axi_rvalid  = (rd_st_r == RD_RESP);
	assign s_axi_rdata   = rdata_r;
	assign s_axi_rresp   = rresp_r;

	// Controls to the core come straight from the stored bits
	assign irq_ctrl_enable = lib_en_r;
	assign irq_ctrl_base   = lib_base_r;

	// Feature enables mirror the writable power-on bits
	always_comb begin
		feature_en.data_err_chk   = hpc_rw_r[PCM_HPC_DATA_CHK_BIT];
		feature_en.resp_err_chk   = hpc_rw_r[PCM_HPC_RESP_CHK_BIT];
		feature_en.addr_err_drive = hpc_rw_r[PCM_HPC_AERR_DRV_BIT];
		feature_en.bus_err_req    = hpc_rw_r[PCM_HPC_BERR_REQ_BIT];
		feature_en.bus_err_int    = hpc_rw_r[PCM_HPC_BERR_INT_BIT];
		feature_en.bus_init_drive = hpc_rw_r[PCM_HPC_BINIT_BIT];
		feature_en.low_power      = hpc_rw_r[PCM_HPC_LOWPWR_BIT];
	end

endmodule

// ==== testbench/pcm_msr_bank_sva.sv ====
// Port-level checks of the configuration register bank
`timescale 1ns/1ps
module pcm_msr_bank_sva
	import pcm_pkg::*;
#(
	parameter logic EN_RST = PCM_LIB_EN_RST
) (
	input wire logic        sys_clk,
	input wire logic        rst,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic        irq_ctrl_enable,
	input wire logic [19:0] irq_ctrl_base,
	input wire pcm_feat_t   feature_en
);
	// One clock domain, so one default clock and reset
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);

	// Write answer: one hold cycle, then the response
	chk_wr_latency: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("write response not two cycles later");
	chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	chk_aw_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while response pending");
	chk_rd_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
		else $error("read answer changed before taken");
	chk_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while answer pending");
	chk_err_zero: assert property (s_axi_rvalid && s_axi_rresp != PCM_RESP_OKAY |-> s_axi_rdata == 32'h0)
		else $error("error read returned data");
	chk_en_sticky: assert property (!irq_ctrl_enable |=> !irq_ctrl_enable)
		else $error("controller enable set again without reset");
	// Reset values must hold regardless of what the bus did before
	chk_rst_values: assert property (disable iff (1'b0) rst |=> irq_ctrl_enable == EN_RST && feature_en == 7'h00)
		else $error("wrong control values after reset");
	// Controls may only move when a write completes
	chk_upd_at_b: assert property (!$stable({feature_en, irq_ctrl_base, irq_ctrl_enable}) |-> $rose(s_axi_bvalid))
		else $error("control output changed outside a write");

	cov_write: cover property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready);
	cov_read: cover property (s_axi_rvalid && s_axi_rready);
	cov_en_off: cover property ($fell(irq_ctrl_enable));
	cov_err: cover property (s_axi_rvalid && s_axi_rresp == PCM_RESP_DECERR);
endmodule

bind pcm_msr_bank pcm_msr_bank_sva #(.EN_RST(EN_RST)) chk_u (.sys_clk, .rst, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
	.irq_ctrl_enable, .irq_ctrl_base, .feature_en);

// ==== testbench/pcm_msr_bank_tb.sv ====
// Self-checking bench for the configuration register bank
`timescale 1ns/1ps
module pcm_msr_bank_tb;
	import pcm_pkg::*;
	logic        sys_clk = 1'b0;
	logic        rst = 1'b1;
	logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0]  s_axi_wstrb = 4'h0;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	pcm_strap_t  strap_pins = {3'h5, 4'hC, 1'h1, 1'h1, 32'h5A5A_A5A5};
	logic        irq_ctrl_enable;
	logic [19:0] irq_ctrl_base;
	pcm_feat_t   feature_en;
	int          n_errors = 0, tests_run = 0;

	// 100 MHz clock
	always #5 sys_clk = ~sys_clk;

	pcm_msr_bank dut_u (.sys_clk, .rst, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .strap_pins,
		.irq_ctrl_enable, .irq_ctrl_base, .feature_en);

	// Expected register words, built field by field
	function automatic logic [31:0] pid_hi(input pcm_strap_t s);
		return {3'h0, s.clock_ratio, 3'h0, s.cache_latency, s.platform_flag, 18'h0};
	endfunction
	function automatic logic [31:0] irq_lo(input logic [19:0] b, input logic e, input logic p);
		return {b, e, 2'h0, p, 8'h00};
	endfunction
	function automatic logic [31:0] pon_lo(input logic [31:0] w);
		return (w & PCM_HPC_RW_MASK[31:0]) | (strap_pins.poweron & PCM_HPC_RO_MASK[31:0]);
	endfunction
	function automatic logic [31:0] feat(input logic [31:0] w);
		return {25'h0, w[1], w[2], w[3], w[4], w[6], w[7], w[26]};
	endfunction

	task automatic close_out;
		$display("checks %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Write: address and data offered together, each dropped once taken
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
		input logic [1:0] er);
		@(posedge sys_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		// No cycle count is assumed here: only the watchdog may end a hung wait
		forever begin
			@(posedge sys_clk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) break;
		end
		s_axi_bready <= 1'b0;
		chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
		@(posedge sys_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		// Wait for the answer however long it takes; the watchdog catches a hang
		forever begin
			@(posedge sys_clk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		s_axi_rready <= 1'b0;
		chk("rdata", e, s_axi_rdata);
		chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
	endtask

	// Straps pass a two-stage synchroniser, so allow a few edges
	task automatic strap_set(input pcm_strap_t v);
		@(posedge sys_clk);
		strap_pins <= v;
		repeat (4) @(posedge sys_clk);
	endtask

	task automatic t_platform;
		pcm_strap_t v;
		rd(12'h05C, 32'h0, PCM_RESP_OKAY);
		for (int i = 0; i < 8; i++) begin
			v = strap_pins;
			v.platform_flag = i[2:0];
			v.cache_latency = 4'hA ^ i[3:0];
			v.clock_ratio = i[0];
			v.bootstrap_processor = i[1];
			strap_set(v);
			rd(12'h15C, pid_hi(v), PCM_RESP_OKAY);
			rd(12'h06C, irq_lo(20'h0, 1'b1, v.bootstrap_processor), PCM_RESP_OKAY);
		end
		wr(12'h15C, 32'hFFFF_FFFF, 4'hF, PCM_RESP_OKAY);
		rd(12'h15C, pid_hi(v), PCM_RESP_OKAY);
		$display("platform test done");
	endtask

	task automatic t_poweron;
		rd(12'h0A8, pon_lo(32'h0), PCM_RESP_OKAY);
		wr(12'h0A8, 32'hFFFF_FFFF, 4'hF, PCM_RESP_OKAY);
		rd(12'h0A8, pon_lo(32'hFFFF_FFFF), PCM_RESP_OKAY);
		chk("features", feat(32'hFFFF_FFFF), {25'h0, feature_en});
		wr(12'h1A8, 32'hFFFF_FFFF, 4'hF, PCM_RESP_OKAY);
		rd(12'h1A8, 32'h0, PCM_RESP_OKAY);
		// Only the lowest byte lane is written, so bit 26 must survive
		wr(12'h0A8, 32'h0, 4'h1, PCM_RESP_OKAY);
		rd(12'h0A8, pon_lo(32'hFFFF_FF00), PCM_RESP_OKAY);
		chk("features", feat(32'hFFFF_FF00), {25'h0, feature_en});
		wr(12'h0A8, 32'h0000_0002, 4'hF, PCM_RESP_OKAY);
		chk("data check", 32'h1, {31'h0, feature_en.data_err_chk});
		$display("power-on test done");
	endtask

	task automatic t_irq;
		logic p;
		p = strap_pins.bootstrap_processor;
		wr(12'h06C, 32'hABCD_EFFF, 4'hF, PCM_RESP_OKAY);
		rd(12'h06C, irq_lo(20'hABCDE, 1'b1, p), PCM_RESP_OKAY);
		chk("base", 32'h000A_BCDE, {12'h0, irq_ctrl_base});
		wr(12'h06C, 32'hABCD_E000, 4'hF, PCM_RESP_OKAY);
		chk("enable", 32'h0, {31'h0, irq_ctrl_enable});
		wr(12'h06C, 32'hABCD_E800, 4'hF, PCM_RESP_OKAY);
		rd(12'h06C, irq_lo(20'hABCDE, 1'b0, p), PCM_RESP_OKAY);
		// Only a reset may bring the controller back
		@(posedge sys_clk);
		rst <= 1'b1;
		repeat (3) @(posedge sys_clk);
		rst <= 1'b0;
		repeat (4) @(posedge sys_clk);
		chk("enable", 32'h1, {31'h0, irq_ctrl_enable});
		rd(12'h06C, irq_lo(20'h0, 1'b1, p), PCM_RESP_OKAY);
		$display("interrupt base test done");
	endtask

	task automatic t_err;
		logic [11:0] a[5] = '{12'h000, 12'h004, 12'h040, 12'h008, 12'h25C};
		logic [1:0]  r[5] = '{2'h2, 2'h2, 2'h2, 2'h3, 2'h3};
		for (int i = 0; i < 5; i++) begin
			wr(a[i], 32'hFFFF_FFFF, 4'hF, r[i]);
			rd(a[i], 32'h0, r[i]);
		end
		rd(12'h0A8, pon_lo(32'h0), PCM_RESP_OKAY);
		$display("error test done");
	endtask

	// Main sequence
	initial begin
		repeat (20) @(posedge sys_clk);
		rst <= 1'b0;
		repeat (4) @(posedge sys_clk);
		t_platform;
		t_poweron;
		t_irq;
		t_err;
		close_out;
	end

	// Watchdog, far beyond the few hundred cycles the tests need
	initial begin
		repeat (20000) @(posedge sys_clk);
		n_errors++;
		close_out;
	end
endmodule
